/* hdl/sub_unit.sv */
// subtract instruction datapath: literal and file register forms
// assumes decode delivers one instruction per issue pulse
// Summary of operation
// - the literal form loads literal minus accumulator into accumulator.
// - the register form reads file register by 7-bit index, minus acc.
// - register form with target 0 writes accumulator only.
// - register form with target 1 writes the file register only.
// - carry is 1 when minuend exceeds accumulator.
// - carry is 1 when minuend equals accumulator.
// - carry is 0 when accumulator exceeds minuend; result wraps mod 256.
`timescale 1ns/1ps
`include "sub_unit_map.svh"
module sub_unit
  import sub_unit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // instruction issue
  input wire logic issue,
  input wire logic is_register_form,
  input wire logic [`DATA_W-1:0] literal,
  input wire logic [`INDEX_W-1:0] file_index,
  input wire logic target_sel,
  // results
  output logic [`DATA_W-1:0] accumulator,
  output logic carry,
  output logic nibble_borrow_flag,
  output logic zero,
  output logic done
);
  // all state in one word: result, flags, the pending register-form
  // operation and the one-cycle completion pulse
  typedef struct packed {
    logic [`DATA_W-1:0] acc;
    flags_t flags;
    sub_op_t op;
    logic [`INDEX_W-1:0] index;
    logic target;
    logic done;
  } state_t;

  state_t s_q, s_d;
  file_port_if fport ();

  // ----------------------------------------
  // arithmetic helper
  // ----------------------------------------
  // minuend + ~acc + 1: carry out is the no-borrow flag
  function automatic logic [`DATA_W:0] sub9(
    input logic [`DATA_W-1:0] a, input logic [`DATA_W-1:0] b);
    sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction : sub9

  // low-nibble copy of the same sum: its carry out is the nibble flag,
  // so no separate borrow chain has to be kept
  function automatic logic [`NIBBLE_W:0] sub5(
    input logic [`NIBBLE_W-1:0] a, input logic [`NIBBLE_W-1:0] b);
    sub5 = {1'b0, a} + {1'b0, ~b} + 5'h01;
  endfunction : sub5

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  // the flags assume a nibble of half the word and a memory that the
  // index covers exactly; refuse a header edited out of step
  if (`NIBBLE_W * 2 != `DATA_W) begin : g_bad_nibble
    $error("sub_unit nibble must be half the data width");
  end
  if ((1 << `INDEX_W) != `FILE_DEPTH) begin : g_bad_index
    $error("sub_unit index width must cover the file memory");
  end

  // ----------------------------------------
  // file register memory
  // ----------------------------------------
  // read data are registered, which is why the register form needs a
  // second clock; the write port is driven from the next-state logic
  file_regs #(.DEPTH(`FILE_DEPTH)) u_regs (
    .clk(clk),
    .port(fport.mem)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // register form latches index at issue; file data arrive next cycle,
  // so the register form executes in the cycle after issue
  logic [`DATA_W-1:0] minuend;
  logic [`DATA_W:0] diff;
  logic [`NIBBLE_W:0] ndiff;
  always_comb begin
    // defaults: pulses drop and no operation stays pending
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.op = op_none;
    minuend = (s_q.op == op_register_minus_accumulator)
      ? fport.rd_data : literal;
    diff = sub9(minuend, s_q.acc);
    ndiff = sub5(minuend[`NIBBLE_W-1:0], s_q.acc[`NIBBLE_W-1:0]);
    // index goes straight to the memory so the data stand next cycle
    fport.rd_index = file_index;
    // the write port always carries the difference; wr_en alone decides
    fport.wr_en = 1'b0;
    fport.wr_index = s_q.index;
    fport.wr_data = diff[`DATA_W-1:0];
    case (s_q.op)
      // second cycle of the register form: any issue now is refused
      op_register_minus_accumulator: begin
        s_d.done = 1'b1;
        if (s_q.target == `DEST_FILE) begin
          fport.wr_en = 1'b1;
        end else begin
          s_d.acc = diff[`DATA_W-1:0];
        end
        s_d.flags.carry = diff[`DATA_W];
        s_d.flags.nibble_borrow_flag = ndiff[`NIBBLE_W];
        s_d.flags.zero = (diff[`DATA_W-1:0] == '0);
      end
      // idle: the literal form finishes on this edge, the register form
      // only records index and target and waits for the memory
      default: begin
        if (issue && !is_register_form) begin
          s_d.acc = diff[`DATA_W-1:0];
          s_d.flags.carry = diff[`DATA_W];
          s_d.flags.nibble_borrow_flag = ndiff[`NIBBLE_W];
          s_d.flags.zero = (diff[`DATA_W-1:0] == '0);
          s_d.done = 1'b1;
        end else if (issue) begin
          s_d.op = op_register_minus_accumulator;
          s_d.index = file_index;
          s_d.target = target_sel;
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // constants only in the reset branch; the file memory keeps its words
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{acc: `ACC_RESET, flags: '0, op: op_none, index: '0,
        target: 1'b0, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a field of the state register, none is combinational
  assign accumulator = s_q.acc;
  assign carry = s_q.flags.carry;
  assign nibble_borrow_flag = s_q.flags.nibble_borrow_flag;
  assign zero = s_q.flags.zero;
  assign done = s_q.done;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // expected values come from the operands one edge back (same cycle for file_write_a), never from the
  // adder above, so a broken carry chain cannot hide behind itself

  // literal form
  literal_result_a: assert property (
    issue && !is_register_form && s_q.op == op_none |=>
      accumulator == 8'(($past(literal) - $past(accumulator))) && done)
    else $error("literal result wrong");
  literal_carry_a: assert property (
    issue && !is_register_form && s_q.op == op_none |=>
      carry == ($past(literal) >= $past(accumulator)))
    else $error("literal carry wrong");
  literal_zero_a: assert property (
    issue && !is_register_form && s_q.op == op_none |=>
      zero == ($past(literal) == $past(accumulator)))
    else $error("literal zero flag wrong");
  nibble_flag_a: assert property (
    issue && !is_register_form && s_q.op == op_none |=>
      nibble_borrow_flag == ($past(literal[`NIBBLE_W-1:0]) >=
        $past(accumulator[`NIBBLE_W-1:0])))
    else $error("nibble flag wrong");

  // register form
  register_done_a: assert property (
    issue && s_q.op == op_none && is_register_form |=> !done ##1 done)
    else $error("register form timing wrong");
  refused_issue_a: assert property (
    s_q.op == op_register_minus_accumulator |=> s_q.op == op_none)
    else $error("issue taken during register form");
  reg_acc_result_a: assert property (
    s_q.op == op_register_minus_accumulator && !s_q.target |=>
      accumulator == 8'($past(fport.rd_data) - $past(accumulator)))
    else $error("register form result wrong");
  acc_kept_a: assert property (
    s_q.op == op_register_minus_accumulator && s_q.target |=>
      $stable(accumulator))
    else $error("accumulator changed on file target");
  file_write_a: assert property (
    fport.wr_en |-> fport.wr_index == s_q.index &&
      fport.wr_data == 8'(fport.rd_data - s_q.acc))
    else $error("file write wrong");
  file_untouched_a: assert property (
    s_q.op == op_register_minus_accumulator && !s_q.target |->
      !fport.wr_en)
    else $error("file written on acc target");

  // flags of the register form
  equal_carry_a: assert property (
    s_q.op == op_register_minus_accumulator &&
      fport.rd_data == s_q.acc |=> carry && zero)
    else $error("equal operands carry wrong");
  borrow_clear_a: assert property (
    s_q.op == op_register_minus_accumulator &&
      fport.rd_data < s_q.acc |=> !carry && !zero)
    else $error("borrow carry wrong");
  zero_flag_a: assert property (
    s_q.op == op_register_minus_accumulator |=>
      zero == ($past(fport.rd_data) == $past(accumulator)))
    else $error("zero flag wrong");
  reg_nibble_a: assert property (
    s_q.op == op_register_minus_accumulator |=>
      nibble_borrow_flag == ($past(fport.rd_data[`NIBBLE_W-1:0]) >=
        $past(accumulator[`NIBBLE_W-1:0])))
    else $error("register nibble flag wrong");

  // scenarios worth seeing
  lit_cov_c: cover property (issue && !is_register_form);
  reg_file_c: cover property (fport.wr_en);
  reg_acc_c: cover property (
    s_q.op == op_register_minus_accumulator && !s_q.target);
  equal_c: cover property (done && zero && carry);
  borrow_c: cover property (done && !carry);
endmodule : sub_unit

/* common/sub_unit_map.svh */
// constants for the subtract instruction unit
// assumes inclusion from the package and design files by bare name
`ifndef SUB_UNIT_MAP_SVH
`define SUB_UNIT_MAP_SVH
`define DATA_W 8
`define INDEX_W 7
`define NIBBLE_W 4
`define ACC_RESET 8'h00
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`define FILE_DEPTH 128
`endif

/* common/sub_unit_pkg.sv */
// types shared by the subtract instruction unit
// assumes the constant header sits beside it
`include "sub_unit_map.svh"
package sub_unit_pkg;
  // ----------------------------------------
  // instruction selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    op_none,
    op_literal_minus_accumulator,
    op_register_minus_accumulator
  } sub_op_t;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  typedef struct packed {
    logic carry;
    logic nibble_borrow_flag;
    logic zero;
  } flags_t;
endpackage : sub_unit_pkg

/* common/file_port_if.sv */
// file register access channel between unit and register file
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "sub_unit_map.svh"
interface file_port_if;
  logic [`INDEX_W-1:0] rd_index;
  logic [`DATA_W-1:0] rd_data;
  logic wr_en;
  logic [`INDEX_W-1:0] wr_index;
  logic [`DATA_W-1:0] wr_data;
  modport user (output rd_index, output wr_en, output wr_index,
    output wr_data, input rd_data);
  modport mem (input rd_index, input wr_en, input wr_index,
    input wr_data, output rd_data);
endinterface : file_port_if

/* hdl/file_regs.sv */
// file register memory, registered read data
// assumes read index is presented one cycle before data are used
`timescale 1ns/1ps
`include "sub_unit_map.svh"
module file_regs #(
  parameter int DEPTH = `FILE_DEPTH
) (
  // clock
  input wire logic clk,
  // access
  file_port_if.mem port
);
  // zero at power-up so a read before the first write is defined; there
  // is still no reset, so the contents survive arst_n like a ram
  logic [`DATA_W-1:0] mem_q [DEPTH] = '{default: '0};
  logic [`DATA_W-1:0] rd_q;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // the index reaches exactly this many words, no more and no fewer
  if (DEPTH != (1 << `INDEX_W)) begin : g_bad_depth
    $error("file_regs depth must match the index width");
  end

  // read first (a same-word write returns old data), read registered; memory holds no reset to stay ram-like
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_q[port.wr_index] <= port.wr_data;
    end
    rd_q <= mem_q[port.rd_index];
  end
  assign port.rd_data = rd_q;
endmodule : file_regs

/* test/sub_unit_tb.sv */
// self-checking bench for the subtract instruction unit
// assumes the file memory starts at zero and is reached only by the unit
`timescale 1ns/1ps
`include "sub_unit_map.svh"
module sub_unit_tb;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic issue = 1'b0;
  logic is_register_form = 1'b0;
  logic [`DATA_W-1:0] literal = 8'h00;
  logic [`INDEX_W-1:0] file_index = 7'h00;
  logic target_sel = 1'b0;
  logic [`DATA_W-1:0] accumulator;
  logic carry, nibble_borrow_flag, zero, done;
  logic [`DATA_W-1:0] acc_m;
  logic [`DATA_W-1:0] mem_m = 8'h00; // model of the file register in use
  int n_mismatch = 0;
  int checked = 0;
  always #2 clk = ~clk;
  sub_unit uut (.clk(clk), .arst_n(arst_n), .issue(issue),
    .is_register_form(is_register_form), .literal(literal),
    .file_index(file_index), .target_sel(target_sel),
    .accumulator(accumulator), .carry(carry),
    .nibble_borrow_flag(nibble_borrow_flag), .zero(zero), .done(done));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // reset held 6 cycles; every output must read zero afterwards
  task automatic t_reset();
    @(posedge clk) arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk("acc", accumulator, 8'h00);
    chk("flags", {4'h0, carry, nibble_borrow_flag, zero, done}, 8'h00);
    acc_m = 8'h00;
  endtask : t_reset
  // expectation reckoned from the bench model, not the outputs
  task automatic expect_lit(input logic [7:0] k);
    logic [7:0] d;
    logic nb;
    d = k - acc_m;
    nb = k[3:0] >= acc_m[3:0];
    chk("acc", accumulator, d);
    chk("carry", {7'h00, carry}, {7'h00, k >= acc_m});
    chk("nibble", {7'h00, nibble_borrow_flag}, {7'h00, nb});
    chk("zero", {7'h00, zero}, {7'h00, d == 8'h00});
    chk("done", {7'h00, done}, 8'h01);
    acc_m = d;
  endtask : expect_lit
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // one literal op, then an idle edge with done low and acc held
  task automatic t_lit(input logic [7:0] k);
    @(posedge clk) issue <= 1'b1;
    literal <= k;
    @(posedge clk) issue <= 1'b0;
    #1 expect_lit(k);
    @(posedge clk) #1 chk("done low", {7'h00, done}, 8'h00);
    chk("acc hold", accumulator, acc_m);
  endtask : t_lit
  // single literal ops over sign, zero and nibble-borrow corners
  task automatic t_single();
    logic [7:0] ks [8];
    ks = '{8'h02, 8'h02, 8'h01, 8'h00, 8'hff, 8'h10, 8'h0f, 8'h20};
    foreach (ks[i]) t_lit(ks[i]);
  endtask : t_single
  // literal ops issued back to back, one per edge
  task automatic t_back();
    @(posedge clk) issue <= 1'b1;
    literal <= 8'h80;
    @(posedge clk) literal <= 8'h7f;
    #1 expect_lit(8'h80);
    @(posedge clk) issue <= 1'b0;
    #1 expect_lit(8'h7f);
  endtask : t_back
  // register form with a literal issue refused in its second cycle
  task automatic t_reg(input logic tgt);
    logic [7:0] d;
    logic cy;
    logic nb;
    d = mem_m - acc_m;
    cy = mem_m >= acc_m;
    nb = mem_m[3:0] >= acc_m[3:0];
    @(posedge clk) issue <= 1'b1;
    is_register_form <= 1'b1;
    file_index <= 7'h7f;
    target_sel <= tgt;
    @(posedge clk) is_register_form <= 1'b0;
    literal <= 8'h55;
    #1 chk("done early", {7'h00, done}, 8'h00);
    @(posedge clk) issue <= 1'b0;
    #1 chk("done reg", {7'h00, done}, 8'h01);
    chk("reg carry", {7'h00, carry}, {7'h00, cy});
    chk("reg nibble", {7'h00, nibble_borrow_flag}, {7'h00, nb});
    chk("reg zero", {7'h00, zero}, {7'h00, d == 8'h00});
    if (tgt) mem_m = d;
    else acc_m = d;
    chk("reg acc", accumulator, acc_m);
    @(posedge clk) #1 chk("refused", {7'h00, done}, 8'h00);
    chk("refused acc", accumulator, acc_m);
  endtask : t_reg
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset();
    t_single();
    t_back();
    t_reg(1'b1); // borrow: file register written, acc kept
    t_reg(1'b0); // reads the written value minus acc into acc
    t_lit(8'ha0); // acc now matches the untouched file register
    t_reg(1'b1); // equal operands: zero result, no borrow
    t_reset();
    t_single();
    close_out();
  end
  // generous span: the sequence needs well under 200 cycles
  initial begin
    #8000;
    n_mismatch++;
    close_out();
  end
endmodule : sub_unit_tb
